//--- chip_regs_cfg.svh
// Offsets, field layout, reset values and sizes of the chip-level register bank
`ifndef CHIP_REGS_CFG_SVH
`define CHIP_REGS_CFG_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_TX_RED_LO      8'h00
`define IDX_RX_RED_LO      8'h08
`define IDX_IRQ_EN_LO      8'h60
`define IDX_IRQ_ST_LO      8'h61
`define IDX_IRQ_CLR_LO     8'h62
`define IDX_PART_NUM       8'h6E
`define IDX_REVISION       8'h6F
`define IDX_TX_RED_HI      8'h80
`define IDX_RX_RED_HI      8'h88
`define IDX_IRQ_EN_HI      8'hE0
`define IDX_IRQ_ST_HI      8'hE1
`define IDX_IRQ_CLR_HI     8'hE2

// ****************************************************************
// Field layout and sizes
// ****************************************************************
`define ADDR_W             10
`define IDX_W              8
`define IDX_LSB            2
`define REG_W              8
`define GROUP_CHANS        6
`define NUM_CHANS          12
`define FIELD_MASK         8'h3F
`define LOW_BYTE_MSB       7
`define REG_RESET          8'h00
`define CHAN_RESET         6'h00
`define WORD_ZERO          32'h0000_0000
`define ALIGN_ZERO         2'h0

// Arbitrary identification values
`define PART_NUM_DEFAULT   8'h5A
`define REVISION_DEFAULT   8'h01

`endif

//--- chip_regs_pkg.sv
// Types shared by the chip-level register bank
package chip_regs_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [9:0]  paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_type;

   typedef struct packed {
      logic [11:0] pos;
      logic [11:0] neg;
      logic [11:0] oe;
   } line_drive_type;

   typedef enum logic [1:0] {
      PH_IDLE   = 2'b01,
      PH_ACCESS = 2'b10
   } apb_phase_type;

endpackage

//--- global_chip_register_bank.sv
// Chip-level register bank: driver enables, redundancy control, channel interrupts, ID
`timescale 1ns/1ps
`default_nettype none
`include "chip_regs_cfg.svh"

// How it works
// [R01] Transmit-redundancy registers read/write at index 0x00 and 0x80.
// [R02] Receive-redundancy registers read/write at index 0x08 and 0x88.
// [R03] Channel interrupt enable registers read/write at index 0x60 and 0xE0.
// [R04] Channel interrupt status registers read-only at index 0x61 and 0xE1.
// [R05] Part number at 0x6E and revision at 0x6F are fixed and unwritable.
// [R06] Index 0x00 bits 0-5 switch drivers of channels 0-5; bits 7,6 reserved.
// [R07] Index 0x08 bits 0-5 switch drivers of channels 6-11; bits 7,6 reserved.
// [R08] A driver-on bit of one enables that channel's line output pair.
// [R09] A driver-on bit of zero releases both line outputs to high impedance.
// [R10] Driver runs only while master enable pin is high AND the bit is set.
// [R11] Cleared channel interrupt enable blocks that channel from the interrupt output.
// [R12] Reserved bits read zero and ignore writes.
module global_chip_register_bank
   import chip_regs_pkg::*;
#(
   parameter logic [7:0] PART_NUM = `PART_NUM_DEFAULT,
   parameter logic [7:0] REVISION = `REVISION_DEFAULT,
   parameter int         NCH      = `NUM_CHANS
) (
   input  wire logic           clk,
   input  wire logic           nrst,
   input  wire apb_req_type    apb_req,
   output var  apb_rsp_type    apb_rsp,
   input  wire logic           master_drv_en_pin,
   input  wire logic [11:0]    chan_event,
   input  wire logic [11:0]    tx_pos_data,
   input  wire logic [11:0]    tx_neg_data,
   output var  line_drive_type line_drv,
   output var  logic           irq
);

   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ****************************************************************
   // Address decode
   // ****************************************************************
   function automatic logic idx_hit(input logic [`IDX_W-1:0] idx,
                                    input logic [`IDX_W-1:0] code);
      idx_hit = (idx == code);
   endfunction

   wire logic [`IDX_W-1:0] req_idx;
   wire logic              req_aligned;
   wire logic              sel_tx_lo;
   wire logic              sel_rx_lo;
   wire logic              sel_tx_hi;
   wire logic              sel_rx_hi;
   wire logic              sel_ie_lo;
   wire logic              sel_ie_hi;
   wire logic              sel_is_lo;
   wire logic              sel_is_hi;
   wire logic              sel_ic_lo;
   wire logic              sel_ic_hi;
   wire logic              sel_pn;
   wire logic              sel_rev;
   wire logic              mapped;

   assign req_idx     = apb_req.paddr[`ADDR_W-1:`IDX_LSB];
   assign req_aligned = (apb_req.paddr[`IDX_LSB-1:0] == `ALIGN_ZERO);
   assign sel_tx_lo   = req_aligned & idx_hit(req_idx, `IDX_TX_RED_LO);
   assign sel_rx_lo   = req_aligned & idx_hit(req_idx, `IDX_RX_RED_LO);
   assign sel_tx_hi   = req_aligned & idx_hit(req_idx, `IDX_TX_RED_HI);
   assign sel_rx_hi   = req_aligned & idx_hit(req_idx, `IDX_RX_RED_HI);
   assign sel_ie_lo   = req_aligned & idx_hit(req_idx, `IDX_IRQ_EN_LO);
   assign sel_ie_hi   = req_aligned & idx_hit(req_idx, `IDX_IRQ_EN_HI);
   assign sel_is_lo   = req_aligned & idx_hit(req_idx, `IDX_IRQ_ST_LO);
   assign sel_is_hi   = req_aligned & idx_hit(req_idx, `IDX_IRQ_ST_HI);
   assign sel_ic_lo   = req_aligned & idx_hit(req_idx, `IDX_IRQ_CLR_LO);
   assign sel_ic_hi   = req_aligned & idx_hit(req_idx, `IDX_IRQ_CLR_HI);
   assign sel_pn      = req_aligned & idx_hit(req_idx, `IDX_PART_NUM);
   assign sel_rev     = req_aligned & idx_hit(req_idx, `IDX_REVISION);
   assign mapped      = sel_tx_lo | sel_rx_lo | sel_tx_hi | sel_rx_hi
                      | sel_ie_lo | sel_ie_hi | sel_is_lo | sel_is_hi
                      | sel_ic_lo | sel_ic_hi | sel_pn | sel_rev;

   // ****************************************************************
   // Bus phase tracking
   // ****************************************************************
   apb_phase_type phase_r;
   apb_phase_type phase_nxt;
   apb_rsp_type   rsp_r;

   wire logic setup_cyc;
   wire logic access_fire;
   wire logic wr_fire;

   assign setup_cyc   = apb_req.psel & ~apb_req.penable;
   // Completion counts only in the access phase, never on a stale ready
   assign access_fire = (phase_r == PH_ACCESS) & apb_req.psel & apb_req.penable
                      & rsp_r.pready;
   // Only byte lane 0 carries register bits
   assign wr_fire     = access_fire & apb_req.pwrite & apb_req.pstrb[0] & mapped;

   // One-hot phase; an illegal code falls back to idle
   always_comb begin
      phase_nxt = phase_r;
      unique case (phase_r)
         PH_IDLE: begin
            if (setup_cyc) begin
               phase_nxt = PH_ACCESS;
            end
         end
         PH_ACCESS: begin
            if (access_fire) begin
               phase_nxt = PH_IDLE;
            end
         end
         default: begin
            phase_nxt = PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         phase_r <= PH_IDLE;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // ****************************************************************
   // Control registers
   // ****************************************************************
   logic [`GROUP_CHANS-1:0] tx_redundancy_ctrl_lo_r;
   logic [`GROUP_CHANS-1:0] rx_redundancy_ctrl_lo_r;
   logic [`GROUP_CHANS-1:0] tx_redundancy_ctrl_hi_r;
   logic [`GROUP_CHANS-1:0] rx_redundancy_ctrl_hi_r;
   logic [NCH-1:0]          chan_irq_enable_r;
   logic [NCH-1:0]          chan_irq_status_r;

   wire logic [`GROUP_CHANS-1:0] wr_field;
   wire logic [NCH-1:0]          clr_mask;

   // Bits 7 and 6 are never stored, so writes to them are dropped
   assign wr_field = apb_req.pwdata[`GROUP_CHANS-1:0]; // [R12]
   // Write-only clear: a one clears that channel, a zero leaves it
   assign clr_mask = {(wr_fire & sel_ic_hi) ? wr_field : `CHAN_RESET,
                      (wr_fire & sel_ic_lo) ? wr_field : `CHAN_RESET};

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         tx_redundancy_ctrl_lo_r <= `CHAN_RESET;
         rx_redundancy_ctrl_lo_r <= `CHAN_RESET;
         tx_redundancy_ctrl_hi_r <= `CHAN_RESET;
         rx_redundancy_ctrl_hi_r <= `CHAN_RESET;
      end else if (wr_fire) begin
         if (sel_tx_lo) begin
            tx_redundancy_ctrl_lo_r <= wr_field; // [R01] [R06]
         end
         if (sel_tx_hi) begin
            tx_redundancy_ctrl_hi_r <= wr_field; // [R01]
         end
         if (sel_rx_lo) begin
            rx_redundancy_ctrl_lo_r <= wr_field; // [R02] [R07]
         end
         if (sel_rx_hi) begin
            rx_redundancy_ctrl_hi_r <= wr_field; // [R02]
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         chan_irq_enable_r <= {NCH{1'b0}};
      end else if (wr_fire & sel_ie_lo) begin
         chan_irq_enable_r[`GROUP_CHANS-1:0] <= wr_field; // [R03]
      end else if (wr_fire & sel_ie_hi) begin
         chan_irq_enable_r[NCH-1:`GROUP_CHANS] <= wr_field; // [R03]
      end
   end

   // ****************************************************************
   // Sticky channel interrupt status
   // ****************************************************************
   // Status is never written through the bus; only the clear register lowers it
   genvar ch;
   wire logic [NCH-1:0] status_nxt;

   generate
      for (ch = 0; ch < NCH; ch++) begin : g_status
         // Set beats a clear in the same cycle so no event is lost
         assign status_nxt[ch] = chan_event[ch] | (chan_irq_status_r[ch] & ~clr_mask[ch]); // [R04]
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         chan_irq_status_r <= {NCH{1'b0}};
      end else begin
         chan_irq_status_r <= status_nxt; // [R04]
      end
   end

   logic irq_r;
   wire logic [NCH-1:0] irq_pending;

   assign irq_pending = chan_irq_status_r & chan_irq_enable_r; // [R11]

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |irq_pending; // [R11]
      end
   end

   // ****************************************************************
   // Master driver enable pin
   // ****************************************************************
   logic pin_s1_r;
   logic pin_s2_r;
   logic pin_s3_r;
   logic drv_en_r;

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_s3_r <= 1'b0;
         drv_en_r <= 1'b0;
      end else begin
         pin_s1_r <= master_drv_en_pin;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         // Change accepted only once two stages agree, rejects single-cycle glitches
         if (pin_s2_r == pin_s3_r) begin
            drv_en_r <= pin_s2_r;
         end
      end
   end

   // ****************************************************************
   // Line drivers
   // ****************************************************************
   wire logic [NCH-1:0] driver_on;
   wire logic [NCH-1:0] drive_ok;
   wire line_drive_type line_nxt;
   line_drive_type      line_r;

   // Upper group follows the register at index 0x08, as its bit table lays out
   // Registers at 0x80 and 0x88 are storage only; they steer no driver
   assign driver_on = {rx_redundancy_ctrl_lo_r, tx_redundancy_ctrl_lo_r}; // [R06] [R07]
   assign drive_ok  = driver_on & {NCH{drv_en_r}}; // [R10]

   generate
      for (ch = 0; ch < NCH; ch++) begin : g_line
         // Off: both pins released together, data parked low
         assign line_nxt.oe[ch]  = drive_ok[ch]; // [R08] [R09]
         assign line_nxt.pos[ch] = drive_ok[ch] & tx_pos_data[ch]; // [R08] [R09]
         assign line_nxt.neg[ch] = drive_ok[ch] & tx_neg_data[ch]; // [R08] [R09]
      end
   endgenerate

   // Data registered with its enable so both pins switch together
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         line_r <= '0;
      end else begin
         line_r <= line_nxt;
      end
   end

   // ****************************************************************
   // Read data and bus answer
   // ****************************************************************
   function automatic logic [`REG_W-1:0] pad_field(input logic [`GROUP_CHANS-1:0] field);
      pad_field = {{(`REG_W-`GROUP_CHANS){1'b0}}, field}; // [R12]
   endfunction

   wire logic [`REG_W-1:0] rd_byte;
   wire logic [31:0]       rd_word;
   wire logic [`REG_W-1:0] tx_lo_rd;
   wire logic [`REG_W-1:0] rx_lo_rd;
   wire logic [`REG_W-1:0] tx_hi_rd;
   wire logic [`REG_W-1:0] rx_hi_rd;
   wire logic [`REG_W-1:0] ie_lo_rd;
   wire logic [`REG_W-1:0] ie_hi_rd;
   wire logic [`REG_W-1:0] is_lo_rd;
   wire logic [`REG_W-1:0] is_hi_rd;

   // Reserved bits 7,6 come back as zero
   assign tx_lo_rd = pad_field(tx_redundancy_ctrl_lo_r); // [R12]
   assign rx_lo_rd = pad_field(rx_redundancy_ctrl_lo_r); // [R12]
   assign tx_hi_rd = pad_field(tx_redundancy_ctrl_hi_r); // [R12]
   assign rx_hi_rd = pad_field(rx_redundancy_ctrl_hi_r); // [R12]
   assign ie_lo_rd = pad_field(chan_irq_enable_r[`GROUP_CHANS-1:0]); // [R03]
   assign ie_hi_rd = pad_field(chan_irq_enable_r[NCH-1:`GROUP_CHANS]); // [R03]
   assign is_lo_rd = pad_field(chan_irq_status_r[`GROUP_CHANS-1:0]); // [R04]
   assign is_hi_rd = pad_field(chan_irq_status_r[NCH-1:`GROUP_CHANS]); // [R04]
   // Clear registers hold no state and read back zero
   assign rd_byte = ({`REG_W{sel_tx_lo}} & tx_lo_rd)
                  | ({`REG_W{sel_rx_lo}} & rx_lo_rd)
                  | ({`REG_W{sel_tx_hi}} & tx_hi_rd)
                  | ({`REG_W{sel_rx_hi}} & rx_hi_rd)
                  | ({`REG_W{sel_ie_lo}} & ie_lo_rd)
                  | ({`REG_W{sel_ie_hi}} & ie_hi_rd)
                  | ({`REG_W{sel_is_lo}} & is_lo_rd) // [R04]
                  | ({`REG_W{sel_is_hi}} & is_hi_rd) // [R04]
                  | ({`REG_W{sel_pn}}    & PART_NUM)  // [R05]
                  | ({`REG_W{sel_rev}}   & REVISION); // [R05]
   assign rd_word = 32'(rd_byte);

   // Answer arrives in the first access cycle; read data is a snapshot at setup
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rsp_r <= '0;
      end else if (setup_cyc) begin
         rsp_r.pready  <= 1'b1;
         rsp_r.pslverr <= ~mapped;
         rsp_r.prdata  <= (apb_req.pwrite | ~mapped) ? `WORD_ZERO : rd_word;
      end else if (access_fire) begin
         rsp_r <= '0;
      end
   end

   assign apb_rsp  = rsp_r;
   assign line_drv = line_r;
   assign irq      = irq_r;

endmodule
`default_nettype wire

//--- chip_regs_sva.sv
// Port-level concurrent checks for the chip-level register bank
`timescale 1ns/1ps
`default_nettype none
`include "chip_regs_cfg.svh"
module chip_regs_sva
   import chip_regs_pkg::*;
#(
   parameter logic [7:0] PART_NUM = 8'h00,
   parameter logic [7:0] REVISION = 8'h00
) (
   input wire logic           clk,
   input wire logic           nrst,
   input wire apb_req_type    apb_req,
   input wire apb_rsp_type    apb_rsp,
   input wire logic           master_drv_en_pin,
   input wire logic [11:0]    chan_event,
   input wire logic [11:0]    tx_pos_data,
   input wire logic [11:0]    tx_neg_data,
   input wire line_drive_type line_drv,
   input wire logic           irq
);
   // ************************
   // Bus phase decode
   // ************************
   default clocking dc @(posedge clk); endclocking
   default disable iff (!nrst);
   wire       setup_w  = apb_req.psel && !apb_req.penable;
   wire       rsetup_w = setup_w && !apb_req.pwrite && apb_req.paddr[1:0] == 2'h0;
   wire       wacc_w   = apb_req.psel && apb_req.penable && apb_req.pwrite;
   wire [7:0] idx_w    = apb_req.paddr[9:2];
   // ************************
   // Assertions
   // ************************
   ready_after_setup_a: assert property (setup_w |=> apb_rsp.pready)
      else $error("no ready after setup");
   ready_cause_a: assert property (apb_rsp.pready |-> $past(setup_w) ##1 !apb_rsp.pready)
      else $error("ready without setup or too long");
   err_with_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
      else $error("error flag without ready");
   upper_zero_a: assert property (apb_rsp.prdata[31:8] == 24'h0)
      else $error("read data above byte not zero");
   part_read_a: assert property (rsetup_w && idx_w == `IDX_PART_NUM |=>
      apb_rsp.prdata == {24'h0, PART_NUM}) else $error("part number read wrong");
   rev_read_a: assert property (rsetup_w && idx_w == `IDX_REVISION |=>
      apb_rsp.prdata == {24'h0, REVISION}) else $error("revision read wrong");
   idle_pins_a: assert property (((line_drv.pos | line_drv.neg) & ~line_drv.oe) == 12'h0)
      else $error("line driven while disabled");
   line_data_a: assert property (line_drv.pos == ($past(tx_pos_data) & line_drv.oe) &&
      line_drv.neg == ($past(tx_neg_data) & line_drv.oe)) else $error("line data wrong");
   // Sync takes a few edges, so six low samples leave margin
   pin_off_a: assert property (!master_drv_en_pin [*6] |=> line_drv.oe == 12'h0)
      else $error("driver on with master pin low");
   irq_hold_a: assert property (irq && !wacc_w && !$past(wacc_w) |=> irq)
      else $error("interrupt dropped without write");
   irq_cause_a: assert property ($rose(irq) |->
      $past(chan_event != 12'h0, 2) || $past(wacc_w, 2)) else $error("interrupt without cause");
   cover property (wacc_w && apb_rsp.pready);
   cover property ($rose(irq));
   cover property (line_drv.oe != 12'h0);
endmodule
bind global_chip_register_bank chip_regs_sva #(.PART_NUM(PART_NUM), .REVISION(REVISION)) chk_u (
   .clk, .nrst, .apb_req, .apb_rsp, .master_drv_en_pin, .chan_event,
   .tx_pos_data, .tx_neg_data, .line_drv, .irq);
`default_nettype wire

//--- apb_host_model.sv
// Host processor model: APB master issuing single register transfers
`timescale 1ns/1ps
`default_nettype none
module apb_host_model
   import chip_regs_pkg::*;
(
   input  wire logic        clk,
   output var  apb_req_type apb_req,
   input  wire apb_rsp_type apb_rsp
);
   // ************************
   // Transfer task
   // ************************
   initial apb_req = '0;
   // Enter just after a rising edge; returns one edge after release,
   // so a following call never drives the bus twice in one time step
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      apb_req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: {idx, 2'h0},
                   pwdata: wd, pstrb: 4'hF};
      @(posedge clk);
      apb_req.penable <= 1'h1;
      // No wait limit here: the bench watchdog ends a hang
      do @(posedge clk); while (apb_rsp.pready !== 1'h1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

//--- global_chip_register_bank_test.sv
// Self-checking testbench for the chip-level register bank
`timescale 1ns/1ps
`default_nettype none
`include "chip_regs_cfg.svh"
module global_chip_register_bank_test;
   import chip_regs_pkg::*;
   // ************************
   // Setup
   // ************************
   localparam logic [7:0] PN = 8'hA5;  // Arbitrary identification value
   localparam logic [7:0] RV = 8'h3C;  // Arbitrary identification value
   localparam logic [7:0] RW_IDX [6] = '{`IDX_TX_RED_LO, `IDX_RX_RED_LO, `IDX_TX_RED_HI,
                                         `IDX_RX_RED_HI, `IDX_IRQ_EN_LO, `IDX_IRQ_EN_HI};
   localparam logic [7:0] RO_IDX [4] = '{`IDX_IRQ_ST_LO, `IDX_IRQ_ST_HI, `IDX_PART_NUM,
                                         `IDX_REVISION};
   localparam logic [7:0] RO_EXP [4] = '{8'h00, 8'h00, PN, RV};
   localparam logic [11:0] PAT [2] = '{12'hA5C, 12'h3F0};
   logic           clk        = 1'h0;
   logic           nrst       = 1'h0;
   logic           drv_pin    = 1'h1;
   logic [11:0]    chan_event = 12'h000;
   logic [11:0]    tx_pos     = 12'h000;
   logic [11:0]    tx_neg     = 12'h000;
   apb_req_type    apb_req;
   apb_rsp_type    apb_rsp;
   line_drive_type line_drv;
   logic           irq;
   logic [31:0]    rd;
   logic           er;
   int             err_total  = 0;
   int             checks     = 0;

   global_chip_register_bank #(.PART_NUM(PN), .REVISION(RV)) dut_u (
      .clk               (clk),
      .nrst              (nrst),
      .apb_req           (apb_req),
      .apb_rsp           (apb_rsp),
      .master_drv_en_pin (drv_pin),
      .chan_event        (chan_event),
      .tx_pos_data       (tx_pos),
      .tx_neg_data       (tx_neg),
      .line_drv          (line_drv),
      .irq               (irq)
   );
   apb_host_model host_u (.clk(clk), .apb_req(apb_req), .apb_rsp(apb_rsp));

   always #12.5 clk = ~clk;
   // ************************
   // Tasks
   // ************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      host_u.xfer(1'h1, idx, d, rd, er);
   endtask
   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      host_u.xfer(1'h0, idx, 32'h0, rd, er);
      chk(rd, exp);
   endtask
   task automatic wrap_up();
      $display("Counts: %0d compares, %0d mismatches", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ************************
   // Tests
   // ************************
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'h1;
      repeat (3) @(posedge clk);
      chk(line_drv.oe, 12'h000);
      foreach (RW_IDX[i]) begin
         rd_chk(RW_IDX[i], 32'h0);
         wr(RW_IDX[i], 32'hFFFF_FFEA);
         rd_chk(RW_IDX[i], 32'h2A);
         wr(RW_IDX[i], 32'h1234_5615);
         rd_chk(RW_IDX[i], 32'h15);
      end
      $display("test read-write registers done");
      foreach (RO_IDX[i]) begin
         rd_chk(RO_IDX[i], {24'h0, RO_EXP[i]});
         wr(RO_IDX[i], {24'hFFFFFF, ~RO_EXP[i]});
         rd_chk(RO_IDX[i], {24'h0, RO_EXP[i]});
      end
      host_u.xfer(1'h0, 8'h10, 32'h0, rd, er);
      chk(er, 1'h1);
      chk(rd, 32'h0);
      $display("test read-only and unmapped done");
      wr(`IDX_TX_RED_LO, 32'h05);
      wr(`IDX_RX_RED_LO, 32'h30);
      foreach (PAT[i]) begin
         tx_pos <= PAT[i];
         tx_neg <= ~PAT[i];
         repeat (2) @(posedge clk);
         chk(line_drv.oe, 12'hC05);
         chk(line_drv.pos, PAT[i] & 12'hC05);
         chk(line_drv.neg, ~PAT[i] & 12'hC05);
      end
      drv_pin <= 1'h0;
      // Pin sync plus output register settle well within eight edges
      repeat (8) @(posedge clk);
      chk(line_drv.oe, 12'h000);
      chk(line_drv.pos | line_drv.neg, 12'h000);
      drv_pin <= 1'h1;
      repeat (8) @(posedge clk);
      chk(line_drv.oe, 12'hC05);
      wr(`IDX_TX_RED_LO, 32'h04);
      repeat (2) @(posedge clk);
      chk(line_drv.oe, 12'hC04);
      $display("test line drivers done");
      wr(`IDX_IRQ_EN_LO, 32'h01);
      wr(`IDX_IRQ_EN_HI, 32'h00);
      chan_event <= 12'h041;
      @(posedge clk);
      chan_event <= 12'h000;
      repeat (3) @(posedge clk);
      chk(irq, 1'h1);
      rd_chk(`IDX_IRQ_ST_LO, 32'h01);
      rd_chk(`IDX_IRQ_ST_HI, 32'h01);
      wr(`IDX_IRQ_EN_LO, 32'h00);
      repeat (2) @(posedge clk);
      chk(irq, 1'h0);
      wr(`IDX_IRQ_EN_HI, 32'h01);
      repeat (2) @(posedge clk);
      chk(irq, 1'h1);
      wr(`IDX_IRQ_CLR_HI, 32'h01);
      repeat (2) @(posedge clk);
      chk(irq, 1'h0);
      rd_chk(`IDX_IRQ_ST_HI, 32'h00);
      rd_chk(`IDX_IRQ_ST_LO, 32'h01);
      // Event lands on the clearing edge and must survive it
      fork
         wr(`IDX_IRQ_CLR_LO, 32'h01);
         begin
            @(posedge clk);
            chan_event <= 12'h001;
            @(posedge clk);
            chan_event <= 12'h000;
         end
      join
      rd_chk(`IDX_IRQ_ST_LO, 32'h01);
      wr(`IDX_IRQ_CLR_LO, 32'h01);
      rd_chk(`IDX_IRQ_ST_LO, 32'h00);
      rd_chk(`IDX_IRQ_CLR_LO, 32'h00);
      $display("test interrupts done");
      wrap_up();
   end
   // Tests need well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      wrap_up();
   end
endmodule
`default_nettype wire
